// >>> src/bmw_regs.svh
// Offsets, field positions, reset values and constants of the window registers
`ifndef BMW_REGS_SVH
`define BMW_REGS_SVH

`define BMW_OFF_MEM_LOW 8'h20
`define BMW_OFF_MEM_HIGH 8'h22
`define BMW_OFF_PREF_LOW 8'h24
`define BMW_OFF_PREF_HIGH 8'h26
`define BMW_OFF_PREF_LOW_UP 8'h28
`define BMW_OFF_PREF_HIGH_UP 8'h2c

`define BMW_FLD_MSB 15
`define BMW_FLD_LSB 4
`define BMW_FLD_W 12
`define BMW_LOW_W 20

`define BMW_RST_MEM 16'h0000
`define BMW_RST_PREF 16'h0001
`define BMW_RST_UP 32'h00000000
`define BMW_RST_FLD 12'h000

`define BMW_RSVD_NIBBLE 4'h0
`define BMW_WIDE_FLAG 4'h1
`define BMW_LOW_ZERO 20'h00000
`define BMW_LOW_ONES 20'hfffff
`define BMW_UP_ZERO 32'h00000000
`define BMW_RD_NONE 32'h00000000

`endif

// >>> src/bmw_pkg.sv
// Types shared by the bridge memory window register bank
package bmw_pkg;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} bmw_cfg_req_t;

	typedef struct packed {
		logic valid;
		logic [63:0] addr;
	} bmw_mem_req_t;

	typedef struct packed {
		logic valid;
		logic forward;
		logic mem_hit;
		logic pref_hit;
	} bmw_fwd_t;

endpackage

// >>> src/bmw_top.sv
// Memory and prefetchable window registers with forwarding decode
`timescale 1ns/100ps
`include "bmw_regs.svh"

// Functional notes
// - Memory base field gives address bits 31:20, low zeros
// - Memory limit field gives bits 31:20, low ones
// - Forward memory cycles inside a programmed window
// - Memory base/limit bits 3:0 read zero
// - Prefetch base field gives bits 31:20, low zeros
// - Prefetch limit field gives bits 31:20, low ones
// - Prefetch bits 3:0 read 1, 64-bit flag
// - Offset 28h holds prefetch base bits 63:32
// - Offset 2Ch holds prefetch limit bits 63:32
// - Memory base and limit reset to zero
// - Prefetch base upper is 32-bit, resets zero
// - Prefetch limit upper is full 32-bit read/write
module bmw_top (
	input wire logic core_clk,
	input wire logic rst,
	input wire bmw_pkg::bmw_cfg_req_t cfg_req,
	output logic [31:0] cfg_rdata,
	output logic cfg_rvalid,
	input wire bmw_pkg::bmw_mem_req_t mem_req,
	output bmw_pkg::bmw_fwd_t fwd
);
	import bmw_pkg::*;

	logic [11:0] mem_window_low;
	logic [11:0] mem_window_high;
	logic [11:0] prefetch_window_low;
	logic [11:0] prefetch_window_high;
	logic [31:0] prefetch_base_high;
	logic [31:0] prefetch_limit_high;

	logic [11:0] next_mem_window_low;
	logic [11:0] next_mem_window_high;
	logic [11:0] next_prefetch_window_low;
	logic [11:0] next_prefetch_window_high;
	logic [31:0] next_prefetch_base_high;
	logic [31:0] next_prefetch_limit_high;
	logic [31:0] next_cfg_rdata;
	logic next_cfg_rvalid;
	bmw_fwd_t next_fwd;

	logic [31:0] mem_word;
	logic [31:0] pref_word;
	logic [31:0] mem_merged;
	logic [31:0] pref_merged;
	logic [31:0] mem_lo_addr;
	logic [31:0] mem_hi_addr;
	logic [63:0] pref_lo_addr;
	logic [63:0] pref_hi_addr;
	logic mem_empty;
	logic pref_empty;
	logic mem_in;
	logic pref_in;

	// Selects the dword that holds a given byte offset
	function automatic logic dword_hit(input logic [7:0] addr,
		input logic [7:0] off);
		dword_hit = (addr[7:2] == off[7:2]);
	endfunction

	// Byte-enable merge of write data into a stored dword
	function automatic logic [31:0] be_merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[8*i +: 8] = nw[8*i +: 8];
			end
		end
		be_merge = res;
	endfunction

	// Dword views; base in low half, limit in high half
	always_comb begin
		mem_word = {mem_window_high, `BMW_RSVD_NIBBLE,
			mem_window_low, `BMW_RSVD_NIBBLE};
		pref_word = {prefetch_window_high, `BMW_WIDE_FLAG,
			prefetch_window_low, `BMW_WIDE_FLAG};
		mem_merged = be_merge(mem_word, cfg_req.wdata, cfg_req.be);
		pref_merged = be_merge(pref_word, cfg_req.wdata, cfg_req.be);
	end

	// Window bounds
	always_comb begin
		mem_lo_addr = {mem_window_low, `BMW_LOW_ZERO};
		mem_hi_addr = {mem_window_high, `BMW_LOW_ONES};
		pref_lo_addr = {prefetch_base_high, prefetch_window_low,
			`BMW_LOW_ZERO};
		pref_hi_addr = {prefetch_limit_high, prefetch_window_high,
			`BMW_LOW_ONES};
		mem_empty = (mem_lo_addr > mem_hi_addr);
		pref_empty = (pref_lo_addr > pref_hi_addr);
		mem_in = (mem_req.addr[63:32] == `BMW_UP_ZERO)
			&& (mem_req.addr[31:0] >= mem_lo_addr)
			&& (mem_req.addr[31:0] <= mem_hi_addr);
		pref_in = (mem_req.addr >= pref_lo_addr)
			&& (mem_req.addr <= pref_hi_addr);
	end

	// Register writes
	always_comb begin
		next_mem_window_low = mem_window_low;
		next_mem_window_high = mem_window_high;
		next_prefetch_window_low = prefetch_window_low;
		next_prefetch_window_high = prefetch_window_high;
		next_prefetch_base_high = prefetch_base_high;
		next_prefetch_limit_high = prefetch_limit_high;
		if (cfg_req.wr) begin
			if (dword_hit(cfg_req.addr, `BMW_OFF_MEM_LOW)) begin
				next_mem_window_low =
					mem_merged[`BMW_FLD_MSB:`BMW_FLD_LSB];
				next_mem_window_high =
					mem_merged[31:20];
			end
			if (dword_hit(cfg_req.addr, `BMW_OFF_PREF_LOW)) begin
				next_prefetch_window_low =
					pref_merged[`BMW_FLD_MSB:`BMW_FLD_LSB];
				next_prefetch_window_high =
					pref_merged[31:20];
			end
			if (dword_hit(cfg_req.addr, `BMW_OFF_PREF_LOW_UP)) begin
				next_prefetch_base_high = be_merge(prefetch_base_high,
					cfg_req.wdata, cfg_req.be);
			end
			if (dword_hit(cfg_req.addr, `BMW_OFF_PREF_HIGH_UP)) begin
				next_prefetch_limit_high = be_merge(prefetch_limit_high,
					cfg_req.wdata, cfg_req.be);
			end
		end
	end

	// Register reads; unmapped dwords read zero
	always_comb begin
		next_cfg_rvalid = cfg_req.rd;
		next_cfg_rdata = `BMW_RD_NONE;
		if (cfg_req.rd) begin
			if (dword_hit(cfg_req.addr, `BMW_OFF_MEM_LOW)) begin
				next_cfg_rdata = mem_word;
			end else if (dword_hit(cfg_req.addr, `BMW_OFF_PREF_LOW)) begin
				next_cfg_rdata = pref_word;
			end else if (dword_hit(cfg_req.addr,
				`BMW_OFF_PREF_LOW_UP)) begin
				next_cfg_rdata = prefetch_base_high;
			end else if (dword_hit(cfg_req.addr,
				`BMW_OFF_PREF_HIGH_UP)) begin
				next_cfg_rdata = prefetch_limit_high;
			end
		end
	end

	// Forwarding decision
	always_comb begin
		next_fwd.valid = mem_req.valid;
		next_fwd.mem_hit = mem_req.valid && mem_in && !mem_empty;
		next_fwd.pref_hit = mem_req.valid && pref_in
			&& !pref_empty;
		next_fwd.forward = next_fwd.mem_hit || next_fwd.pref_hit;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			mem_window_low <= `BMW_RST_FLD;
			mem_window_high <= `BMW_RST_FLD;
			prefetch_window_low <= `BMW_RST_FLD;
			prefetch_window_high <= `BMW_RST_FLD;
			prefetch_base_high <= `BMW_RST_UP;
			prefetch_limit_high <= `BMW_RST_UP;
			cfg_rdata <= `BMW_RD_NONE;
			cfg_rvalid <= 1'b0;
			fwd <= '0;
		end else begin
			mem_window_low <= next_mem_window_low;
			mem_window_high <= next_mem_window_high;
			prefetch_window_low <= next_prefetch_window_low;
			prefetch_window_high <= next_prefetch_window_high;
			prefetch_base_high <= next_prefetch_base_high;
			prefetch_limit_high <= next_prefetch_limit_high;
			cfg_rdata <= next_cfg_rdata;
			cfg_rvalid <= next_cfg_rvalid;
			fwd <= next_fwd;
		end
	end

	// Checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	a_mem_low_bound: assert property (
		fwd.mem_hit |-> $past(mem_req.addr[31:20]) >= $past(mem_window_low))
		else $error("memory hit below base");

	a_mem_high_bound: assert property (
		fwd.mem_hit |-> $past(mem_req.addr[31:20]) <= $past(mem_window_high)
		&& $past(mem_req.addr[63:32]) == 32'h00000000)
		else $error("memory hit above limit");

	a_fwd_one_cycle: assert property (
		mem_req.valid && mem_req.addr[63:32] == 32'h00000000
		&& mem_req.addr[31:20] == mem_window_low
		&& mem_window_low <= mem_window_high
		&& !(cfg_req.wr) |=> fwd.valid && fwd.forward && fwd.mem_hit)
		else $error("in-window cycle not forwarded");

	a_mem_rsvd_zero: assert property (
		cfg_req.rd && cfg_req.addr[7:2] == 6'h08
		|=> cfg_rvalid && cfg_rdata[3:0] == 4'h0
		&& cfg_rdata[19:16] == 4'h0)
		else $error("reserved memory bits not zero");

	a_pref_low_bound: assert property (
		fwd.pref_hit |-> $past(mem_req.addr[63:20])
		>= $past({prefetch_base_high, prefetch_window_low}))
		else $error("prefetch hit below base");

	a_pref_high_bound: assert property (
		fwd.pref_hit |-> $past(mem_req.addr[63:20])
		<= $past({prefetch_limit_high, prefetch_window_high}))
		else $error("prefetch hit above limit");

	a_wide_flag_read: assert property (
		cfg_req.rd && cfg_req.addr[7:2] == 6'h09
		|=> cfg_rdata[3:0] == 4'h1 && cfg_rdata[19:16] == 4'h1)
		else $error("64-bit flag not reported");

	a_base_up_write: assert property (
		cfg_req.wr && cfg_req.addr[7:2] == 6'h0a && cfg_req.be == 4'hf
		|=> prefetch_base_high == $past(cfg_req.wdata))
		else $error("base upper write lost");

	a_limit_up_read: assert property (
		cfg_req.rd && cfg_req.addr[7:2] == 6'h0b
		|=> cfg_rdata == $past(prefetch_limit_high))
		else $error("limit upper readback wrong");

	a_mem_reset_zero: assert property (
		$past(rst) |-> mem_window_low == 12'h000
		&& mem_window_high == 12'h000)
		else $error("memory window not reset");

	a_base_up_reset: assert property (
		$past(rst) |-> prefetch_base_high == 32'h00000000)
		else $error("base upper not reset");

	a_limit_up_write: assert property (
		cfg_req.wr && cfg_req.addr[7:2] == 6'h0b && cfg_req.be == 4'hf
		|=> prefetch_limit_high == $past(cfg_req.wdata))
		else $error("limit upper write lost");

	a_empty_no_fwd: assert property (
		$past(mem_window_low) > $past(mem_window_high) |-> !fwd.mem_hit)
		else $error("empty window forwarded");

	c_mem_hit: cover property (fwd.mem_hit);
	c_pref_hit: cover property (fwd.pref_hit && !fwd.mem_hit);
	c_miss: cover property (fwd.valid && !fwd.forward);
	c_empty_win: cover property (mem_empty && mem_req.valid);

endmodule

// >>> tb/bmw_far_end.sv
// Far-side source of memory addresses and capture of forward decisions
`timescale 1ns/100ps
module bmw_far_end (
	input wire logic core_clk,
	input wire bmw_pkg::bmw_fwd_t fwd,
	output bmw_pkg::bmw_mem_req_t mem_req
);
	import bmw_pkg::*;
	initial mem_req = '0;
	// Offers one address, returns the decision one cycle later
	task automatic probe(input logic [63:0] a, output bmw_fwd_t f);
		@(posedge core_clk);
		mem_req <= {1'b1, a};
		@(posedge core_clk);
		mem_req <= '0;
		#1;
		f = fwd;
	endtask
endmodule

// >>> tb/tb_bmw_top.sv
// Self-checking bench for the window register bank
`timescale 1ns/100ps
module tb_bmw_top;
	import bmw_pkg::*;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	bmw_cfg_req_t cfg_req = '0;
	logic [31:0] cfg_rdata;
	logic cfg_rvalid;
	bmw_mem_req_t mem_req;
	bmw_fwd_t fwd;
	int fail_count = 0;
	int samples_checked = 0;
	always #2 core_clk = ~core_clk;
	bmw_top bmw_top_inst (
		.core_clk(core_clk),
		.rst(rst),
		.cfg_req(cfg_req),
		.cfg_rdata(cfg_rdata),
		.cfg_rvalid(cfg_rvalid),
		.mem_req(mem_req),
		.fwd(fwd)
	);
	bmw_far_end bmw_far_end_inst (
		.core_clk(core_clk),
		.fwd(fwd),
		.mem_req(mem_req)
	);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [3:0] en,
		input logic [31:0] d);
		@(posedge core_clk);
		cfg_req <= {1'b1, 1'b0, a, en, d};
		@(posedge core_clk);
		cfg_req <= '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		cfg_req <= {1'b0, 1'b1, a, 4'h0, 32'h0};
		@(posedge core_clk);
		cfg_req <= '0;
		#1;
		chk({31'h0, cfg_rvalid}, 32'h1);
		chk(cfg_rdata, exp);
	endtask
	task automatic dec(input logic [63:0] a, input logic m, input logic p);
		bmw_fwd_t f;
		bmw_far_end_inst.probe(a, f);
		chk({28'h0, f}, {28'h0, 1'b1, m | p, m, p});
	endtask
	task automatic give_verdict;
		$display("Checks %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge core_clk);
		fail_count++;
		give_verdict();
	end
	initial begin
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		rd(8'h20, 32'h00000000);
		rd(8'h24, 32'h00010001);
		rd(8'h28, 32'h00000000);
		rd(8'h2c, 32'h00000000);
		rd(8'h30, 32'h00000000);
		dec(64'h0, 1'b1, 1'b1);
		wr(8'h20, 4'hf, 32'h12345678);
		rd(8'h20, 32'h12305670);
		wr(8'h20, 4'hf, 32'h1fff100f);
		rd(8'h20, 32'h1ff01000);
		wr(8'h24, 4'hf, 32'h3ff03000);
		rd(8'h24, 32'h3ff13001);
		wr(8'h28, 4'hf, 32'h00000002);
		wr(8'h28, 4'h2, 32'hffffffff);
		rd(8'h28, 32'h0000ff02);
		wr(8'h28, 4'hf, 32'h00000002);
		wr(8'h2c, 4'hf, 32'h00000002);
		rd(8'h2c, 32'h00000002);
		wr(8'h30, 4'hf, 32'hffffffff);
		rd(8'h30, 32'h00000000);
		dec(64'h10000000, 1'b1, 1'b0);
		dec(64'h0fffffff, 1'b0, 1'b0);
		dec(64'h1fffffff, 1'b1, 1'b0);
		dec(64'h20000000, 1'b0, 1'b0);
		dec(64'h1_10000000, 1'b0, 1'b0);
		dec(64'h2_30000000, 1'b0, 1'b1);
		dec(64'h2_2fffffff, 1'b0, 1'b0);
		dec(64'h2_3fffffff, 1'b0, 1'b1);
		dec(64'h2_40000000, 1'b0, 1'b0);
		dec(64'h3_30000000, 1'b0, 1'b0);
		dec(64'h30000000, 1'b0, 1'b0);
		wr(8'h2c, 4'hf, 32'h00000003);
		dec(64'h3_30000000, 1'b0, 1'b1);
		wr(8'h20, 4'hf, 32'h10002000);
		dec(64'h15000000, 1'b0, 1'b0);
		dec(64'h20000000, 1'b0, 1'b0);
		wr(8'h28, 4'hf, 32'h00000004);
		dec(64'h3_30000000, 1'b0, 1'b0);
		give_verdict();
	end
endmodule
